/* File: hdl/slic_ctrl_pkg.sv */
package slic_ctrl_pkg;
  // register indices, byte address is index times four
  localparam logic [3:0] debounce_time_idx = 4'h4;
  localparam logic [3:0] ch1_level_ctrl_idx = 4'h5;
  localparam logic [3:0] line_if1_ctrl_status_idx = 4'h6;
  localparam logic [3:0] ch1_tone2_ctrl_a_idx = 4'h7;
  localparam logic [3:0] line_if2_ctrl_status_idx = 4'hd;
  localparam logic [3:0] irq_status_idx = 4'h8;
  localparam logic [3:0] irq_enable_idx = 4'h9;
  localparam logic [3:0] irq_clear_idx = 4'ha;
  localparam logic [3:0] pin_status_idx = 4'hb;
  // reset values
  localparam logic [7:0] debounce_time_rst = 8'h00;
  localparam logic [7:0] ch1_level_ctrl_rst = 8'h00;
  localparam logic [5:0] line_if1_ctrl_rst = 6'h00;
  localparam logic [7:0] ch1_tone2_ctrl_a_rst = 8'h00;
  localparam logic [1:0] irq_enable_rst = 2'h0;
  // field positions
  localparam int ch2_debounce_lsb = 4;
  localparam int ch1_debounce_lsb = 0;
  localparam int rx_level_lsb = 4;
  localparam int tx_level_lsb = 0;
  localparam logic [3:0] level_off_code = 4'hf;
  // timing
  localparam int clk_hz = 25000000;
  localparam int debounce_step_ms = 15;
  localparam int ms_tick_cycles = clk_hz / 1000;
  localparam int detmode_on_hold_us = 20;
  localparam int detmode_on_cycles = (clk_hz / 1000000) * detmode_on_hold_us;
  localparam int detmode_pd_hold_ns = 200;
  localparam int detmode_pd_cycles = (detmode_pd_hold_ns * (clk_hz / 1000000)) / 1000;
endpackage

/* File: hdl/slic_ctrl_debounce_regs.sv */
`timescale 1ns/1ps
// Operation
// R01 - the debounce register holds a 4-bit hold code per channel, channel 2 high nibble, channel 1 low nibble.
// R02 - hold time is the code times 15 ms, from 0 to 225 ms.
// R03 - a high-to-low detect edge leaves the detect status and interrupt unchanged for the hold time.
// R04 - the debounce timer runs only while powerdown_n is high, regardless of power-saving bits.
// R05 - channel 1 receive level is the upper level nibble, 1 dB steps, all ones meaning off.
// R06 - channel 1 transmit level is the lower level nibble, same coding, all ones meaning off.
// R07 - the three operating mode pins follow their register bits.
// R08 - the switch control pin follows its bit, zero low for switch on.
// R09 - the battery select pin follows its bit, zero low for low battery.
// R10 - the detector mode pin follows its bit after 20 us powered, or 200 ns powered down.
// R11 - the interrupt output, once low, goes high only after both line-interface registers are read.
// R12 - the detect status bit reports the debounced detect input, zero meaning an event.
// R13 - the alarm status bit reports the thermal alarm input, zero meaning shutdown.
// R14 - writes to the two read-only status bit positions are ignored.
// R15 - debounce and detector-mode hold timers stay active in power-saving mode.
// R16 - a low powerdown_n overrides power saving, and registers stay readable and writable.
// R17 - hold time is counted in millisecond ticks and restarts on each new falling detect edge.
module slic_ctrl_debounce_regs #(
  parameter int ms_cycles = slic_ctrl_pkg::ms_tick_cycles
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic powerdown_n_i,
  input wire logic [1:0] chan_power_save_i,
  input wire logic [1:0] line_event_in_n_i,
  input wire logic li1_thermal_alarm_n_i,
  output logic [3:0] ch1_rx_level_o,
  output logic [3:0] ch1_tx_level_o,
  output logic ch1_rx_off_o,
  output logic ch1_tx_off_o,
  output logic li1_opmode_2_o,
  output logic li1_opmode_1_o,
  output logic li1_opmode_0_o,
  output logic li1_switch_ctl_o,
  output logic li1_battery_sel_o,
  output logic li1_detector_mode_o,
  output logic [7:0] ch1_tone2_ctrl_o,
  output logic [1:0] line_event_deb_o,
  output logic line_irq_n_o,
  output logic irq_o
);
  // register map, word index on address bits 5:2
  //   4  debounce hold codes, channel 2 in the high nibble
  //   5  channel 1 receive level high, transmit level low
  //   6  line interface 1 control, status in bits 1:0
  //   7  channel 1 second tone control, stored and copied out
  //   8  sticky event status, read only
  //   9  interrupt enable, same layout as the status
  //   a  interrupt clear, ones written clear status bits
  //   b  synchronised pin levels, for bring-up
  //   d  line interface 2 status, read only here
  // every other index reads zero and ignores writes

  // bus timing
  // a request is taken in the cycle that waitrequest is high
  // the answer follows one cycle later, always one wait state
  // writes land at the taking edge, reads load the data there
  // read data then stands until the next read is taken
  // only byte lane 0 carries register data

  // reset
  // reset is synchronous and puts every software register to zero
  // detect status comes out of reset as idle (high)
  // the alarm status comes out of reset as normal (high)
  // the line interrupt comes out of reset released
  // pins need two edges to pass the synchronisers

  // power
  // a low powerdown_n stops the millisecond tick
  // a running hold count then freezes, it does not restart
  // the channel power-saving inputs do not stop any timer
  // all registers stay readable and writable when powered down
  // the detector mode delay shortens while powered down

  // debounce
  // a falling detect level loads the hold time in ms
  // the status only goes low once the count runs out
  // a rising detect level releases the status at once
  // a new falling level restarts the hold from the top
  // code zero lets the falling level pass in one cycle
  // the count width covers the largest code times the step

  // line interrupt
  // set on any debounced falling event of either channel
  // released only after both line-interface status reads
  // reads made before the interrupt was set do not count
  // a new event while waiting forgets earlier reads
  // hazard: software must read both registers, in any order

  // sticky status and the level interrupt
  // bit 0 records a debounced event, bit 1 a thermal alarm
  // the alarm bit is set again each cycle the alarm stands
  // a set in the same cycle as a clear wins over the clear
  // irq_o is high while any enabled status bit is set

  // detector mode pin
  // the pin follows its bit only after the hold delay
  // a bit toggled back within the delay never reaches the pin
  // the delay counter restarts whenever pin and bit agree

  // limitation
  // line interface 2 control is not held in this block
  // its status word shows the debounced event and a fixed
  // normal alarm level, enough for the interrupt release

  typedef enum {idle_st, done_st} acc_type;


  logic [7:0] debounce_time_reg;
  logic [7:0] ch1_level_ctrl_reg;
  logic [5:0] li1_ctrl_reg;
  logic [7:0] ch1_tone2_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [1:0] ev_meta_reg;
  logic [1:0] ev_sync_reg;
  logic pd_meta_reg;
  logic pd_sync_reg;
  logic alm_meta_reg;
  logic alm_sync_reg;
  logic [1:0] ev_prev_reg;
  logic [1:0] deb_reg;
  logic [15:0] tick_cnt_reg;
  logic [7:0] ms_left_reg [2];
  logic det_mode_reg;
  logic [9:0] det_hold_reg;
  logic line_irq_reg;
  logic rd1_seen_reg;
  logic rd2_seen_reg;
  acc_type acc_reg;
  logic [31:0] rdata_reg;


  // hold length in ms for a 4-bit code
  function automatic logic [7:0] hold_ms(input logic [3:0] code);
    hold_ms = 8'(code * debounce_step_ms_w());
  endfunction
  function automatic logic [7:0] debounce_step_ms_w();
    debounce_step_ms_w = 8'(slic_ctrl_pkg::debounce_step_ms);
  endfunction



  // bus decode
  wire [3:0] idx = avs_address_i[5:2];
  wire acc_go = (avs_read_i | avs_write_i) & (acc_reg == idle_st);
  wire wr_lo = acc_go & avs_write_i & avs_byteenable_i[0];
  wire rd_go = acc_go & avs_read_i;
  wire wr_deb = wr_lo & (idx == slic_ctrl_pkg::debounce_time_idx);
  wire wr_lvl = wr_lo & (idx == slic_ctrl_pkg::ch1_level_ctrl_idx);
  wire wr_li1 = wr_lo & (idx == slic_ctrl_pkg::line_if1_ctrl_status_idx);
  wire wr_tg = wr_lo & (idx == slic_ctrl_pkg::ch1_tone2_ctrl_a_idx);
  wire wr_ien = wr_lo & (idx == slic_ctrl_pkg::irq_enable_idx);
  wire wr_iclr = wr_lo & (idx == slic_ctrl_pkg::irq_clear_idx);
  wire rd_li1 = rd_go & (idx == slic_ctrl_pkg::line_if1_ctrl_status_idx);
  wire rd_li2 = rd_go & (idx == slic_ctrl_pkg::line_if2_ctrl_status_idx);
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (acc_reg == idle_st);
  assign avs_readdata_o = rdata_reg;



  // read mux; line interface 2 exposes only its status bits here
  logic [7:0] rmux;
  always_comb begin
    case (idx)
      slic_ctrl_pkg::debounce_time_idx: rmux = debounce_time_reg;
      slic_ctrl_pkg::ch1_level_ctrl_idx: rmux = ch1_level_ctrl_reg;
      slic_ctrl_pkg::line_if1_ctrl_status_idx: rmux = {li1_ctrl_reg, deb_reg[0], alm_sync_reg}; // [R12] [R13]
      slic_ctrl_pkg::ch1_tone2_ctrl_a_idx: rmux = ch1_tone2_reg;
      slic_ctrl_pkg::line_if2_ctrl_status_idx: rmux = {6'h00, deb_reg[1], 1'b1};
      slic_ctrl_pkg::irq_status_idx: rmux = {6'h00, irq_status_reg};
      slic_ctrl_pkg::irq_enable_idx: rmux = {6'h00, irq_enable_reg};
      slic_ctrl_pkg::pin_status_idx: rmux = {5'h00, pd_sync_reg, ev_sync_reg};
      default: rmux = 8'h00;
    endcase
  end



  // two-cycle access: request seen, then answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= idle_st;
      rdata_reg <= 32'h0;
    end else begin
      acc_reg <= acc_go ? done_st : idle_st;
      if (rd_go) rdata_reg <= {24'h0, rmux};
    end
  end



  // software registers, kept regardless of power state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debounce_time_reg <= slic_ctrl_pkg::debounce_time_rst;
      ch1_level_ctrl_reg <= slic_ctrl_pkg::ch1_level_ctrl_rst;
      li1_ctrl_reg <= slic_ctrl_pkg::line_if1_ctrl_rst;
      ch1_tone2_reg <= slic_ctrl_pkg::ch1_tone2_ctrl_a_rst;
      irq_enable_reg <= slic_ctrl_pkg::irq_enable_rst;
    end else begin
      if (wr_deb) debounce_time_reg <= avs_writedata_i[7:0]; // [R01] [R16]
      if (wr_lvl) ch1_level_ctrl_reg <= avs_writedata_i[7:0];
      if (wr_li1) li1_ctrl_reg <= avs_writedata_i[7:2]; // [R14]
      if (wr_tg) ch1_tone2_reg <= avs_writedata_i[7:0];
      if (wr_ien) irq_enable_reg <= avs_writedata_i[1:0];
    end
  end



  // pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_meta_reg <= 2'h3;
      ev_sync_reg <= 2'h3;
      pd_meta_reg <= 1'b0;
      pd_sync_reg <= 1'b0;
      alm_meta_reg <= 1'b1;
      alm_sync_reg <= 1'b1;
    end else begin
      ev_meta_reg <= line_event_in_n_i;
      ev_sync_reg <= ev_meta_reg;
      pd_meta_reg <= powerdown_n_i;
      pd_sync_reg <= pd_meta_reg;
      alm_meta_reg <= li1_thermal_alarm_n_i;
      alm_sync_reg <= alm_meta_reg;
    end
  end



  // millisecond tick, halted while powered down
  wire ms_tick = pd_sync_reg & (tick_cnt_reg == 16'(ms_cycles - 1)); // [R04] [R17]
  always_ff @(posedge clk_i) begin
    if (rst_i || !pd_sync_reg) tick_cnt_reg <= 16'h0;
    else if (ms_tick) tick_cnt_reg <= 16'h0;
    else tick_cnt_reg <= tick_cnt_reg + 16'h1;
  end



  // per-channel debounce: falling edges wait the hold time, rising edges pass at once
  wire [1:0] fall = ev_prev_reg & ~ev_sync_reg;
  wire [3:0] code_ch [2];
  assign code_ch[0] = debounce_time_reg[slic_ctrl_pkg::ch1_debounce_lsb +: 4]; // [R01]
  assign code_ch[1] = debounce_time_reg[slic_ctrl_pkg::ch2_debounce_lsb +: 4];
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_deb
      // power-saving bits deliberately ignored here
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ms_left_reg[c] <= 8'h0;
          deb_reg[c] <= 1'b1;
          ev_prev_reg[c] <= 1'b1;
        end else begin
          ev_prev_reg[c] <= ev_sync_reg[c];
          if (ev_sync_reg[c]) begin
            deb_reg[c] <= 1'b1;
            ms_left_reg[c] <= 8'h0;
          end else if (fall[c]) begin
            ms_left_reg[c] <= hold_ms(code_ch[c]); // [R02] [R17]
            if (code_ch[c] == 4'h0) deb_reg[c] <= 1'b0;
          end else if (ms_left_reg[c] != 8'h0) begin
            if (ms_tick) ms_left_reg[c] <= ms_left_reg[c] - 8'h1; // [R03] [R04] [R15]
          end else begin
            deb_reg[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate



  // detector mode pin follows its bit after the hold delay
  wire [9:0] det_hold_len = pd_sync_reg ? 10'(slic_ctrl_pkg::detmode_on_cycles)
                                        : 10'(slic_ctrl_pkg::detmode_pd_cycles);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_mode_reg <= 1'b0;
      det_hold_reg <= 10'h0;
    end else if (det_mode_reg == li1_ctrl_reg[0]) begin
      det_hold_reg <= 10'h0;
    end else if (det_hold_reg >= det_hold_len - 10'h1) begin
      det_mode_reg <= li1_ctrl_reg[0]; // [R10] [R15] [R16]
      det_hold_reg <= 10'h0;
    end else begin
      det_hold_reg <= det_hold_reg + 10'h1;
    end
  end



  // line interrupt: set on debounced event, released after both reads
  wire [1:0] deb_fall;
  logic [1:0] deb_prev_reg;
  assign deb_fall = deb_prev_reg & ~deb_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deb_prev_reg <= 2'h3;
      line_irq_reg <= 1'b0;
      rd1_seen_reg <= 1'b0;
      rd2_seen_reg <= 1'b0;
    end else begin
      deb_prev_reg <= deb_reg;
      if (deb_fall != 2'h0) begin
        line_irq_reg <= 1'b1; // [R03] [R11]
        rd1_seen_reg <= 1'b0;
        rd2_seen_reg <= 1'b0;
      end else if ((rd1_seen_reg | rd_li1) & (rd2_seen_reg | rd_li2)) begin
        line_irq_reg <= 1'b0; // [R11]
        rd1_seen_reg <= 1'b0;
        rd2_seen_reg <= 1'b0;
      end else if (line_irq_reg) begin
        rd1_seen_reg <= rd1_seen_reg | rd_li1;
        rd2_seen_reg <= rd2_seen_reg | rd_li2;
      end
    end
  end



  // sticky status: bit0 debounced event, bit1 thermal alarm; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_status_reg <= 2'h0;
    else irq_status_reg <= (irq_status_reg & ~(wr_iclr ? avs_writedata_i[1:0] : 2'h0))
                           | {~alm_sync_reg, deb_fall != 2'h0};
  end



  // pin outputs
  assign li1_opmode_2_o = li1_ctrl_reg[5]; // [R07]
  assign li1_opmode_1_o = li1_ctrl_reg[4]; // [R07]
  assign li1_opmode_0_o = li1_ctrl_reg[3]; // [R07]
  assign li1_switch_ctl_o = li1_ctrl_reg[2]; // [R08]
  assign li1_battery_sel_o = li1_ctrl_reg[1]; // [R09]
  assign li1_detector_mode_o = det_mode_reg;
  assign ch1_rx_level_o = ch1_level_ctrl_reg[slic_ctrl_pkg::rx_level_lsb +: 4]; // [R05]
  assign ch1_tx_level_o = ch1_level_ctrl_reg[slic_ctrl_pkg::tx_level_lsb +: 4]; // [R06]
  assign ch1_rx_off_o = ch1_rx_level_o == slic_ctrl_pkg::level_off_code; // [R05]
  assign ch1_tx_off_o = ch1_tx_level_o == slic_ctrl_pkg::level_off_code; // [R06]
  assign ch1_tone2_ctrl_o = ch1_tone2_reg;
  assign line_event_deb_o = deb_reg;
  assign line_irq_n_o = ~line_irq_reg;
  assign irq_o = |(irq_status_reg & irq_enable_reg);
endmodule // slic_ctrl_debounce_regs

/* File: tb/line_if_model.sv */
`timescale 1ns/1ps
module line_if_model (
  input wire logic clk_i,
  input wire logic [1:0] hook_req_i,
  input wire logic alarm_req_i,
  output logic [1:0] line_event_in_n_o,
  output logic li1_thermal_alarm_n_o
);
  // detector and alarm outputs, active low, one edge behind the request
  always_ff @(posedge clk_i) begin
    line_event_in_n_o <= ~hook_req_i;
    li1_thermal_alarm_n_o <= ~alarm_req_i;
  end
endmodule // line_if_model

/* File: tb/slic_ctrl_debounce_regs_props.sv */
`timescale 1ns/1ps
module slic_ctrl_props #(parameter int ms_cycles = slic_ctrl_pkg::ms_tick_cycles) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic powerdown_n_i,
  input wire logic [1:0] line_event_in_n_i,
  input wire logic [3:0] ch1_rx_level_o,
  input wire logic [3:0] ch1_tx_level_o,
  input wire logic ch1_rx_off_o,
  input wire logic li1_opmode_2_o,
  input wire logic li1_opmode_1_o,
  input wire logic li1_opmode_0_o,
  input wire logic li1_switch_ctl_o,
  input wire logic li1_battery_sel_o,
  input wire logic li1_detector_mode_o,
  input wire logic [1:0] line_event_deb_o,
  input wire logic line_irq_n_o
);
  // accepted request decode
  wire [3:0] idx = avs_address_i[5:2];
  wire wr_go = avs_write_i && avs_waitrequest_o;
  wire rd_go = avs_read_i && avs_waitrequest_o;
  wire rd_li = rd_go && (idx == 4'h6 || idx == 4'hd);
  wire [4:0] pins = {li1_opmode_2_o, li1_opmode_1_o, li1_opmode_0_o, li1_switch_ctl_o, li1_battery_sel_o};
  logic [3:0] code1_reg;
  // shadow of the channel 1 hold code
  always_ff @(posedge clk_i) begin
    if (rst_i)
      code1_reg <= 4'h0;
    else if (wr_go && idx == 4'h4)
      code1_reg <= avs_writedata_i[3:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");
  AST_RX: assert property (wr_go && idx == 4'h5 |=> ch1_rx_level_o == $past(avs_writedata_i[7:4])
    && ch1_rx_off_o == (&$past(avs_writedata_i[7:4]))) else $error("rx level wrong");
  AST_TX: assert property (wr_go && idx == 4'h5 |=> ch1_tx_level_o == $past(avs_writedata_i[3:0]))
    else $error("tx level wrong");
  AST_OPMODE: assert property (wr_go && idx == 4'h6 |=> pins[4:2] == $past(avs_writedata_i[7:5]))
    else $error("opmode pins wrong");
  AST_SWBAT: assert property (wr_go && idx == 4'h6 |=> pins[1:0] == $past(avs_writedata_i[4:3]))
    else $error("switch or battery pin wrong");
  AST_DETHOLD: assert property (wr_go && idx == 4'h6 && powerdown_n_i
    && avs_writedata_i[2] != li1_detector_mode_o |=> $stable(li1_detector_mode_o)[*8]) else $error("detmode early");
  AST_DEBFALL: assert property ($fell(line_event_deb_o[0]) && code1_reg != 4'h0
    |-> $past(!line_event_in_n_i[0], 300)) else $error("debounce too short");
  AST_DEBRISE: assert property (line_event_in_n_i[0] [*4] |=> line_event_deb_o[0])
    else $error("detect release missed");
  AST_RD6: assert property (rd_go && idx == 4'h6 |=> avs_readdata_o[7:3] == $past(pins)
    && avs_readdata_o[1] == $past(line_event_deb_o[0])) else $error("line status read wrong");
  AST_IRQREL: assert property ($rose(line_irq_n_o) |-> $past(rd_li) || $past(rd_li, 2))
    else $error("line irq released without read");
  // main scenarios
  cover property (wr_go && idx == 4'h6);
  cover property ($fell(line_event_deb_o[0]) && code1_reg != 4'h0);
  cover property ($rose(line_irq_n_o));
endmodule // slic_ctrl_props
bind slic_ctrl_debounce_regs slic_ctrl_props #(.ms_cycles(ms_cycles)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .powerdown_n_i(powerdown_n_i), .line_event_in_n_i(line_event_in_n_i), .ch1_rx_level_o(ch1_rx_level_o),
  .ch1_tx_level_o(ch1_tx_level_o), .ch1_rx_off_o(ch1_rx_off_o), .li1_opmode_2_o(li1_opmode_2_o),
  .li1_opmode_1_o(li1_opmode_1_o), .li1_opmode_0_o(li1_opmode_0_o), .li1_switch_ctl_o(li1_switch_ctl_o),
  .li1_battery_sel_o(li1_battery_sel_o), .li1_detector_mode_o(li1_detector_mode_o),
  .line_event_deb_o(line_event_deb_o), .line_irq_n_o(line_irq_n_o));

/* File: tb/slic_ctrl_debounce_regs_test.sv */
`timescale 1ns/1ps
module slic_ctrl_debounce_regs_test;
  logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, pd_n = 1, alm = 0, alm_n, wq, irq_n, irq, rxo, txo;
  logic op2, op1, op0, sw, bat, detm;
  logic [5:0] addr = 6'h00;
  logic [31:0] wd = 32'h0, q, rdata;
  logic [1:0] hook = 2'h0, ps = 2'h0, ev_n, deb;
  logic [3:0] rxl, txl, be = 4'h1;
  logic [7:0] tone;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  slic_ctrl_debounce_regs #(.ms_cycles(25)) DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wq), .powerdown_n_i(pd_n), .chan_power_save_i(ps), .line_event_in_n_i(ev_n),
    .li1_thermal_alarm_n_i(alm_n), .ch1_rx_level_o(rxl), .ch1_tx_level_o(txl), .ch1_rx_off_o(rxo),
    .ch1_tx_off_o(txo), .li1_opmode_2_o(op2), .li1_opmode_1_o(op1), .li1_opmode_0_o(op0), .li1_switch_ctl_o(sw),
    .li1_battery_sel_o(bat), .li1_detector_mode_o(detm), .ch1_tone2_ctrl_o(tone), .line_event_deb_o(deb),
    .line_irq_n_o(irq_n), .irq_o(irq));
  line_if_model u_line (.clk_i(clk_i), .hook_req_i(hook), .alarm_req_i(alm), .line_event_in_n_o(ev_n),
    .li1_thermal_alarm_n_o(alm_n));
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    addr <= {i, 2'b00};
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input string n, input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(n, {24'h0, e}, q);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    idle(8);
    rst_i <= 1'b0;
    idle(2);
    rdc("debounce", 4'h4, 8'h00);
    rdc("level", 4'h5, 8'h00);
    rdc("line1", 4'h6, 8'h03);
    rdc("tone2", 4'h7, 8'h00);
    rdc("unmapped", 4'h3, 8'h00);
    bus(1'b1, 4'h7, 8'ha5);
    chk("tone2 out", 8'ha5, tone);
    be <= 4'h0;
    bus(1'b1, 4'h7, 8'hff);
    be <= 4'h1;
    rdc("tone2 be", 4'h7, 8'ha5);
    $display("reset test done");
    bus(1'b1, 4'h5, 8'hf3);
    chk("levels", 10'h3e6, {rxl, rxo, txl, txo});
    bus(1'b1, 4'h5, 8'h0e);
    chk("levels", 10'h01c, {rxl, rxo, txl, txo});
    bus(1'b1, 4'h6, 8'h54);
    rdc("line1", 4'h6, 8'h57);
    chk("pins", 5'h0a, {op2, op1, op0, sw, bat});
    chk("detm early", 1'b0, detm);
    idle(600);
    chk("detm late", 1'b1, detm);
    pd_n <= 1'b0;
    bus(1'b1, 4'h6, 8'h50);
    idle(10);
    chk("detm pd", 1'b0, detm);
    rdc("line1 pd", 4'h6, 8'h53);
    $display("pin test done");
    bus(1'b1, 4'h4, 8'h21);
    ps <= 2'h3;
    hook <= 2'h3;
    idle(600);
    chk("deb pd", 2'h3, deb);
    pd_n <= 1'b1;
    idle(340);
    chk("deb hold", 3'h7, {irq_n, deb});
    idle(110);
    chk("deb ch1", 4'h2, {irq, irq_n, deb});
    idle(400);
    chk("deb ch2", 2'h0, deb);
    $display("debounce test done");
    rdc("line1 ev", 4'h6, 8'h51);
    idle(3);
    chk("irq held", 1'b0, irq_n);
    rdc("line2 ev", 4'hd, 8'h01);
    idle(3);
    chk("irq freed", 1'b1, irq_n);
    bus(1'b1, 4'h9, 8'h01);
    idle(2);
    chk("irq on", 1'b1, irq);
    bus(1'b1, 4'ha, 8'h01);
    idle(2);
    chk("irq off", 1'b0, irq);
    alm <= 1'b1;
    idle(5);
    chk("irq masked", 1'b0, irq);
    rdc("line1 alarm", 4'h6, 8'h50);
    rdc("irq status", 4'h8, 8'h02);
    hook <= 2'h0;
    idle(6);
    chk("deb release", 2'h3, deb);
    $display("interrupt test done");
    complete_run();
  end
endmodule // slic_ctrl_debounce_regs_test
